// File: cdq_pkg.sv
package cdq_pkg;
    // Command opcodes and index of the last command block byte
    localparam logic [7:0] OP_CAP = 8'h25;
    localparam logic [7:0] OP_DEF = 8'h37;
    localparam logic [3:0] CDB_LAST = 4'h9;
    // Byte positions inside the command block
    localparam int B_OP = 0;
    localparam int B_REL = 1;
    localparam int B_LBA = 2;
    localparam int B_PMI = 8;
    localparam int B_SEL = 2;
    localparam int B_ALLOC = 7;
    // Bit positions inside those bytes
    localparam int REL_BIT = 0;
    localparam int PMI_BIT = 0;
    localparam int P_BIT = 4;
    localparam int G_BIT = 3;
    localparam int FMT_MSB = 2;
    // Reply sizes in bytes
    localparam logic [15:0] CAP_BYTES = 16'h0008;
    localparam logic [15:0] HDR_BYTES = 16'h0004;
    // Descriptor formats and size shifts (4 or 8 bytes)
    localparam logic [2:0] FMT_BLOCK = 3'h0;
    localparam logic [1:0] SH_SHORT = 2'h2;
    localparam logic [1:0] SH_LONG = 2'h3;
    // Sense keys and additional sense codes
    localparam logic [3:0] SK_NONE = 4'h0;
    localparam logic [3:0] SK_RECOV = 4'h1;
    localparam logic [3:0] SK_MEDIUM = 4'h3;
    localparam logic [3:0] SK_ILLEGAL = 4'h5;
    localparam logic [7:0] ASC_OK = 8'h00;
    localparam logic [7:0] ASC_DL_NF = 8'h1c;
    localparam logic [7:0] ASC_INV_OP = 8'h20;
    localparam logic [7:0] ASC_INV_FIELD = 8'h24;
    // Register byte addresses
    localparam logic [7:0] A_LAST = 8'h00;
    localparam logic [7:0] A_BLEN = 8'h04;
    localparam logic [7:0] A_DLY = 8'h08;
    localparam logic [7:0] A_DCFG = 8'h0c;
    localparam logic [7:0] A_DCNT = 8'h10;
    localparam logic [7:0] A_ISTS = 8'h14;
    localparam logic [7:0] A_IMSK = 8'h18;
    localparam logic [7:0] A_SENSE = 8'h1c;
    // Defect configuration and count fields
    localparam int CFG_PAV = 0;
    localparam int CFG_GAV = 1;
    localparam int CFG_FAULT = 2;
    localparam int CFG_MASK_LSB = 8;
    localparam int CFG_DEF_LSB = 16;
    localparam int CNT_P_LSB = 0;
    localparam int CNT_G_LSB = 16;
    localparam int CNT_W = 12;
    // Interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_CHECK = 1;
    // Command sequencer states
    typedef enum logic [2:0] {ST_IDLE, ST_DEC, ST_PREP, ST_WAIT, ST_TAKE, ST_PUSH, ST_STAT} cdq_state_t;
endpackage : cdq_pkg

// File: cdq_query.sv
// Behaviour
// - Capacity query, flag clear, nonzero address: check, illegal request, invalid field.
// - Flag clear: report last block address and its length in bytes.
// - Flag set: report block before a long delay, never below given address.
// - Capacity reply is eight bytes, address then length, most significant first.
// - Primary list only if asked, grown only if asked; neither gives header only.
// - Both asked: both lists returned, order and merging left to us.
// - No defect data: check, medium error or no sense, list not found.
// - Unsupported requested format: send the list in the default format.
// - Format differs: finish the data, then check with recovered error.
// - Reply opens with four-byte header: indicators, format, length big-endian.
// - Header indicators match lists really sent; format names returned format.
// - Length is descriptor count times four or eight, header excluded.
// - Truncation by allocation length keeps full length and raises no check.
// - Index-format lists are complete; other formats may omit areas.
// - Descriptors are unsorted; count is length over descriptor size.
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
module cdq_query (
    // Clock and reset
    input logic clk,
    input logic rst,
    // Wishbone slave
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_we_i,
    input logic [7:0] wb_adr_i,
    input logic [3:0] wb_sel_i,
    input logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // Command block bytes
    input logic cdb_valid,
    input logic [7:0] cdb_byte,
    output logic cdb_ready,
    // DATA IN byte stream
    output logic din_valid,
    output logic [7:0] din_data,
    input logic din_ready,
    // Completion status
    output logic stat_valid,
    output logic stat_check,
    output logic [3:0] stat_key,
    output logic [7:0] stat_asc,
    // Defect list store
    output logic dl_grown,
    output logic [15:0] dl_addr,
    input logic [7:0] dl_data,
    // Interrupt
    output logic irq
);

    typedef struct packed {
        cdq_pkg::cdq_state_t st;
        logic [3:0] ncdb;
        logic [9:0][7:0] cdb;
        logic is_cap;
        logic [63:0] rep;
        logic [15:0] hdr_n;
        logic [15:0] idx;
        logic [15:0] n;
        logic [15:0] plen;
        logic chk;
        logic [3:0] key;
        logic [7:0] asc;
        logic cdb_rdy;
        logic dv;
        logic [7:0] dout;
        logic dgr;
        logic [15:0] daddr;
        logic sv;
        logic [31:0] last_lba;
        logic [31:0] blen;
        logic [31:0] dly_lba;
        logic [31:0] dcfg;
        logic [31:0] dcnt;
        logic [1:0] ists;
        logic [1:0] imsk;
        logic irq;
        logic ack;
        logic [31:0] rdat;
    } cdq_regs_t;

    cdq_regs_t s_q;
    cdq_regs_t d;

    logic hit;
    logic [1:0] clr;
    logic [1:0] ev;
    logic [7:0] op;
    logic [31:0] c_lba;
    logic c_rel;
    logic c_pmi;
    logic c_preq;
    logic c_greq;
    logic [2:0] c_fmt;
    logic [15:0] c_alloc;
    logic [7:0] fmask;
    logic [2:0] deffmt;
    logic [2:0] ret;
    logic pin;
    logic gin;
    logic [1:0] shl;
    logic [15:0] pbytes;
    logic [15:0] gbytes;
    logic [15:0] dlen;
    logic [16:0] tot;
    logic [15:0] nsend;
    logic [31:0] cap_lba;
    logic [15:0] off;
    logic [63:0] rep_sh;

    // Byte-lane merge for register writes
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : wmerge

    // Command block fields
    assign op = s_q.cdb[cdq_pkg::B_OP];
    assign c_lba = {s_q.cdb[cdq_pkg::B_LBA], s_q.cdb[cdq_pkg::B_LBA+1],
                    s_q.cdb[cdq_pkg::B_LBA+2], s_q.cdb[cdq_pkg::B_LBA+3]};
    assign c_rel = s_q.cdb[cdq_pkg::B_REL][cdq_pkg::REL_BIT];
    assign c_pmi = s_q.cdb[cdq_pkg::B_PMI][cdq_pkg::PMI_BIT];
    assign c_preq = s_q.cdb[cdq_pkg::B_SEL][cdq_pkg::P_BIT];
    assign c_greq = s_q.cdb[cdq_pkg::B_SEL][cdq_pkg::G_BIT];
    assign c_fmt = s_q.cdb[cdq_pkg::B_SEL][cdq_pkg::FMT_MSB:0];
    assign c_alloc = {s_q.cdb[cdq_pkg::B_ALLOC], s_q.cdb[cdq_pkg::B_ALLOC+1]};

    // Defect reply sizing; primary first, grown after, never merged
    assign fmask = s_q.dcfg[cdq_pkg::CFG_MASK_LSB +: 8];
    assign deffmt = s_q.dcfg[cdq_pkg::CFG_DEF_LSB +: 3];
    assign ret = fmask[c_fmt] ? c_fmt : deffmt;
    assign pin = c_preq & s_q.dcfg[cdq_pkg::CFG_PAV];
    assign gin = c_greq & s_q.dcfg[cdq_pkg::CFG_GAV];
    assign shl = (ret == cdq_pkg::FMT_BLOCK) ? cdq_pkg::SH_SHORT : cdq_pkg::SH_LONG;
    assign pbytes = pin ? 16'(s_q.dcnt[cdq_pkg::CNT_P_LSB +: cdq_pkg::CNT_W]) << shl : 16'h0000;
    assign gbytes = gin ? 16'(s_q.dcnt[cdq_pkg::CNT_G_LSB +: cdq_pkg::CNT_W]) << shl : 16'h0000;
    assign dlen = pbytes + gbytes;
    assign tot = 17'(dlen) + 17'(cdq_pkg::HDR_BYTES);
    // Only the byte count shrinks on truncation, never the header length
    assign nsend = (tot > 17'(c_alloc)) ? c_alloc : tot[15:0];

    // Capacity answer: clamp the delay point so it never falls below the asked address
    assign cap_lba = !c_pmi ? s_q.last_lba : ((s_q.dly_lba >= c_lba) ? s_q.dly_lba : c_lba);

    // Stream helpers
    assign off = s_q.idx - cdq_pkg::HDR_BYTES;
    assign rep_sh = s_q.rep << {s_q.idx[2:0], 3'h0};
    assign hit = wb_cyc_i & wb_stb_i & ~s_q.ack;

    // Next-state logic for bus, sequencer and interrupts
    always_comb begin
        d = s_q;
        d.sv = 1'b0;
        d.ack = 1'b0;
        ev = 2'b00;
        clr = 2'b00;
        // Register bus: one wait state, unmapped reads return zero
        if (hit) begin
            d.ack = 1'b1;
            d.rdat = 32'h0000_0000;
            if (wb_adr_i == cdq_pkg::A_LAST) begin
                d.rdat = s_q.last_lba;
                if (wb_we_i) d.last_lba = wmerge(s_q.last_lba, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == cdq_pkg::A_BLEN) begin
                d.rdat = s_q.blen;
                if (wb_we_i) d.blen = wmerge(s_q.blen, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == cdq_pkg::A_DLY) begin
                d.rdat = s_q.dly_lba;
                if (wb_we_i) d.dly_lba = wmerge(s_q.dly_lba, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == cdq_pkg::A_DCFG) begin
                d.rdat = s_q.dcfg;
                if (wb_we_i) d.dcfg = wmerge(s_q.dcfg, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == cdq_pkg::A_DCNT) begin
                d.rdat = s_q.dcnt;
                if (wb_we_i) d.dcnt = wmerge(s_q.dcnt, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == cdq_pkg::A_ISTS) begin
                d.rdat = {30'h0000_0000, s_q.ists};
                if (wb_we_i && wb_sel_i[0]) clr = wb_dat_i[1:0];
            end else if (wb_adr_i == cdq_pkg::A_IMSK) begin
                d.rdat = {30'h0000_0000, s_q.imsk};
                if (wb_we_i && wb_sel_i[0]) d.imsk = wb_dat_i[1:0];
            end else if (wb_adr_i == cdq_pkg::A_SENSE) begin
                d.rdat = {15'h0000, s_q.st != cdq_pkg::ST_IDLE, s_q.asc, 4'h0, s_q.key};
            end
        end
        // Command sequencer
        case (s_q.st)
            cdq_pkg::ST_IDLE: begin
                d.cdb_rdy = 1'b1;
                if (cdb_valid && s_q.cdb_rdy) begin
                    d.cdb[s_q.ncdb] = cdb_byte;
                    if (s_q.ncdb == cdq_pkg::CDB_LAST) begin
                        d.ncdb = 4'h0;
                        d.cdb_rdy = 1'b0;
                        d.st = cdq_pkg::ST_DEC;
                    end else begin
                        d.ncdb = s_q.ncdb + 4'h1;
                    end
                end
            end
            cdq_pkg::ST_DEC: begin
                d.idx = 16'h0000;
                d.n = 16'h0000;
                d.rep = 64'h0000_0000_0000_0000;
                d.plen = 16'h0000;
                d.chk = 1'b0;
                d.key = cdq_pkg::SK_NONE;
                d.asc = cdq_pkg::ASC_OK;
                d.st = cdq_pkg::ST_PREP;
                if (op == cdq_pkg::OP_CAP) begin
                    d.is_cap = 1'b1;
                    d.hdr_n = cdq_pkg::CAP_BYTES;
                    // Relative addressing needs a linked command, which this block lacks
                    if (c_rel || (!c_pmi && c_lba != 32'h0000_0000)) begin
                        d.chk = 1'b1;
                        d.key = cdq_pkg::SK_ILLEGAL;
                        d.asc = cdq_pkg::ASC_INV_FIELD;
                    end else begin
                        d.rep = {cap_lba, s_q.blen};
                        d.n = cdq_pkg::CAP_BYTES;
                    end
                end else if (op == cdq_pkg::OP_DEF) begin
                    d.is_cap = 1'b0;
                    d.hdr_n = cdq_pkg::HDR_BYTES;
                    if (s_q.dcfg[cdq_pkg::CFG_FAULT]) begin
                        d.chk = 1'b1;
                        d.key = cdq_pkg::SK_MEDIUM;
                        d.asc = cdq_pkg::ASC_DL_NF;
                    end else if (!s_q.dcfg[cdq_pkg::CFG_PAV] && !s_q.dcfg[cdq_pkg::CFG_GAV]) begin
                        d.chk = 1'b1;
                        d.key = cdq_pkg::SK_NONE;
                        d.asc = cdq_pkg::ASC_DL_NF;
                    end else begin
                        d.rep = {8'h00, 3'h0, pin, gin, ret, dlen, 32'h0000_0000};
                        d.plen = pbytes;
                        d.n = nsend;
                        if (ret != c_fmt) begin
                            d.chk = 1'b1;
                            d.key = cdq_pkg::SK_RECOV;
                            d.asc = cdq_pkg::ASC_DL_NF;
                        end
                    end
                end else begin
                    d.chk = 1'b1;
                    d.key = cdq_pkg::SK_ILLEGAL;
                    d.asc = cdq_pkg::ASC_INV_OP;
                end
            end
            cdq_pkg::ST_PREP: begin
                // Status only after all bytes went out, so a recovered error follows the data
                if (s_q.idx == s_q.n) begin
                    d.st = cdq_pkg::ST_STAT;
                end else if (s_q.idx < s_q.hdr_n) begin
                    d.dout = rep_sh[63:56];
                    d.dv = 1'b1;
                    d.st = cdq_pkg::ST_PUSH;
                end else begin
                    // Descriptors go out in store order; no sorting is attempted
                    d.dgr = off >= s_q.plen;
                    d.daddr = (off >= s_q.plen) ? off - s_q.plen : off;
                    d.st = cdq_pkg::ST_WAIT;
                end
            end
            cdq_pkg::ST_WAIT: begin
                // One spare cycle lets a registered store answer
                d.st = cdq_pkg::ST_TAKE;
            end
            cdq_pkg::ST_TAKE: begin
                d.dout = dl_data;
                d.dv = 1'b1;
                d.st = cdq_pkg::ST_PUSH;
            end
            cdq_pkg::ST_PUSH: begin
                if (din_ready) begin
                    d.dv = 1'b0;
                    d.idx = s_q.idx + 16'h0001;
                    d.st = cdq_pkg::ST_PREP;
                end
            end
            cdq_pkg::ST_STAT: begin
                d.sv = 1'b1;
                ev[cdq_pkg::IRQ_CHECK] = s_q.chk;
                ev[cdq_pkg::IRQ_DONE] = ~s_q.chk;
                d.st = cdq_pkg::ST_IDLE;
            end
            default: begin
                d.st = cdq_pkg::ST_IDLE;
            end
        endcase
        // A completion landing with a clear keeps its bit
        d.ists = (s_q.ists & ~clr) | ev;
        d.irq = |(d.ists & d.imsk);
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= d;
        end
    end

    // Outputs straight from state
    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdat;
    assign cdb_ready = s_q.cdb_rdy;
    assign din_valid = s_q.dv;
    assign din_data = s_q.dout;
    assign stat_valid = s_q.sv;
    assign stat_check = s_q.chk;
    assign stat_key = s_q.key;
    assign stat_asc = s_q.asc;
    assign dl_grown = s_q.dgr;
    assign dl_addr = s_q.daddr;
    assign irq = s_q.irq;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic in_dec;
    assign in_dec = s_q.st == cdq_pkg::ST_DEC;

    sequence s_end(logic [3:0] k, logic [7:0] a);
        ##3 s_q.sv && s_q.chk && s_q.key == k && s_q.asc == a;
    endsequence

    a_bad_lba_check: assert property (in_dec && op == cdq_pkg::OP_CAP && !c_pmi && c_lba != 32'h0000_0000
        |-> s_end(cdq_pkg::SK_ILLEGAL, cdq_pkg::ASC_INV_FIELD)) else $error("bad address not refused");
    a_last_block: assert property (in_dec && op == cdq_pkg::OP_CAP && !c_pmi && !c_rel && c_lba == 32'h0000_0000
        |=> s_q.rep == {$past(s_q.last_lba), $past(s_q.blen)}) else $error("last block not reported");
    a_pmi_floor: assert property (in_dec && op == cdq_pkg::OP_CAP && c_pmi && !c_rel
        |=> s_q.rep[63:32] >= $past(c_lba)) else $error("delay point below asked address");
    a_cap_order: assert property (s_q.dv && s_q.is_cap && s_q.idx == 16'h0004
        |-> s_q.dout == s_q.rep[31:24]) else $error("capacity byte order wrong");
    a_plist_gate: assert property (s_q.dv && !s_q.is_cap && s_q.idx == 16'h0001
        |-> (!s_q.dout[4] || c_preq) && (!s_q.dout[3] || c_greq)) else $error("unrequested list flagged");
    a_fault_medium: assert property (in_dec && op == cdq_pkg::OP_DEF && s_q.dcfg[cdq_pkg::CFG_FAULT]
        |-> s_end(cdq_pkg::SK_MEDIUM, cdq_pkg::ASC_DL_NF)) else $error("medium fault not reported");
    a_default_fmt: assert property (in_dec && op == cdq_pkg::OP_DEF && !s_q.dcfg[cdq_pkg::CFG_FAULT]
        && (s_q.dcfg[cdq_pkg::CFG_PAV] || s_q.dcfg[cdq_pkg::CFG_GAV]) && !fmask[c_fmt]
        |=> s_q.rep[50:48] == $past(deffmt)) else $error("default format not used");
    a_recov_after: assert property (s_q.sv && s_q.key == cdq_pkg::SK_RECOV
        |-> s_q.idx == s_q.n && !s_q.is_cap) else $error("recovered error before data done");
    a_trunc_clean: assert property (s_q.sv && !s_q.is_cap && s_q.n != 16'h0000 && s_q.key != cdq_pkg::SK_RECOV
        |-> !s_q.chk) else $error("truncation raised a check");
    a_alloc_bound: assert property (s_q.dv && !s_q.is_cap |-> s_q.idx < c_alloc) else $error("sent past allocation");
    a_bad_opcode: assert property (in_dec && op != cdq_pkg::OP_CAP && op != cdq_pkg::OP_DEF
        |-> s_end(cdq_pkg::SK_ILLEGAL, cdq_pkg::ASC_INV_OP)) else $error("unknown opcode accepted");

    // One ack cycle per access, so a request still held is never taken twice
    a_ack_single: assert property (s_q.ack |=> !s_q.ack) else $error("ack held past one cycle");

    // A completion must win over a status clear that lands in the same cycle
    a_status_sticky: assert property (s_q.sv
        |-> (s_q.chk ? s_q.ists[cdq_pkg::IRQ_CHECK] : s_q.ists[cdq_pkg::IRQ_DONE]))
        else $error("completion status bit lost");

    // No command byte is taken while a command is in flight
    a_busy_refuse: assert property (s_q.st != cdq_pkg::ST_IDLE |-> !s_q.cdb_rdy) else $error("ready while busy");

endmodule : cdq_query

// File: cdq_store_model.sv
module cdq_store_model (
    // Clock
    input wire logic clk,
    // Store lookup from the block
    input wire logic dl_grown,
    input wire logic [15:0] dl_addr,
    output logic [7:0] dl_data
);
    timeunit 1ns;
    timeprecision 100ps;

    // Registered store: a byte lands one cycle after the address, the most the block's one wait cycle allows.
    // The pattern mixes list and both address bytes so a wrong list or index shows at once.
    always_ff @(posedge clk) begin
        dl_data <= dl_addr[7:0] ^ dl_addr[15:8] ^ (dl_grown ? 8'ha5 : 8'h3c);
    end
endmodule : cdq_store_model

// File: tb_top.sv
`define CHK(name, exp, got) begin checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("ERROR %s expected %h seen %h", name, exp, got); end end

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // Design ports
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic wb_ack;
    logic [31:0] wb_rdat;
    logic cdb_valid = 1'b0;
    logic [7:0] cdb_byte = 8'h00;
    logic cdb_ready;
    logic din_valid;
    logic [7:0] din_data;
    logic din_ready = 1'b0;
    logic stat_valid;
    logic stat_check;
    logic [3:0] stat_key;
    logic [7:0] stat_asc;
    logic dl_grown;
    logic [15:0] dl_addr;
    logic [7:0] dl_data;
    logic irq;
    // Bench state: counters, expectation queues, mirror of the programmed setup
    int num_errors = 0;
    int checks = 0;
    integer seed = 32'hdba9;
    logic [7:0] exp_q[$];
    logic [12:0] st_q[$];
    logic [31:0] last_lba, blen, dly;
    logic [11:0] cnt_p, cnt_g;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    cdq_query dut_u (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_ack_o(wb_ack), .wb_dat_o(wb_rdat),
        .cdb_valid(cdb_valid), .cdb_byte(cdb_byte), .cdb_ready(cdb_ready), .din_valid(din_valid),
        .din_data(din_data), .din_ready(din_ready), .stat_valid(stat_valid), .stat_check(stat_check),
        .stat_key(stat_key), .stat_asc(stat_asc), .dl_grown(dl_grown), .dl_addr(dl_addr),
        .dl_data(dl_data), .irq(irq));
    cdq_store_model store_u (.clk(clk), .dl_grown(dl_grown), .dl_addr(dl_addr), .dl_data(dl_data));

    // Random stalls on the data stream so hold-until-accepted is exercised
    always @(posedge clk) begin
        logic [31:0] r;
        r = $random(seed);
        din_ready <= (r[1:0] != 2'h0);
    end

    // Monitor: each accepted byte or status pulse takes the oldest note
    always @(posedge clk) begin
        logic [7:0] e;
        logic [12:0] s;
        if (!rst && din_valid === 1'b1 && din_ready === 1'b1) begin
            e = exp_q.size() ? exp_q.pop_front() : 8'hxx;
            `CHK("din_data", e, din_data)
        end
        if (!rst && stat_valid === 1'b1) begin
            s = st_q.size() ? st_q.pop_front() : 13'hx;
            `CHK("data_before_status", 32'h0, 32'(exp_q.size()))
            if (s[12] === 1'b1) `CHK("status", s, {stat_check, stat_key, stat_asc})
            else `CHK("status_check", 1'b0, stat_check)
        end
    end

    function automatic logic [7:0] dl_exp(input logic g, input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ (g ? 8'ha5 : 8'h3c);
    endfunction : dl_exp

    // One classic cycle; the request holds until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (wb_ack !== 1'b1);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wb_xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb_xfer(1'b0, a, 32'h0, q);
        `CHK("reg_read", e, q)
    endtask : rd_chk

    // Sends ten command bytes, then waits until every note has been consumed or 5000 cycles pass
    task automatic cmd(input logic [7:0] op, input logic [7:0] b1, input logic [31:0] lba,
                       input logic [15:0] alloc, input logic [7:0] b8);
        logic [7:0] c[10];
        int k, n;
        c = '{op, b1, lba[31:24], lba[23:16], lba[15:8], lba[7:0], 8'h00, alloc[15:8], alloc[7:0] | b8, 8'h00};
        for (k = 0; k < 10; k++) begin
            cdb_valid <= 1'b1;
            cdb_byte <= c[k];
            do begin
                @(posedge clk);
            end while (cdb_ready !== 1'b1);
        end
        cdb_valid <= 1'b0;
        n = 0;
        while ((exp_q.size() != 0 || st_q.size() != 0) && n < 5000) begin
            @(posedge clk);
            n++;
        end
        `CHK("pending_notes", 32'h0, 32'(exp_q.size() + st_q.size()))
    endtask : cmd

    task automatic push_cap(input logic [31:0] a, input logic [31:0] l);
        logic [63:0] v;
        v = {a, l};
        for (int k = 0; k < 8; k++) exp_q.push_back(v[63 - 8 * k -: 8]);
    endtask : push_cap

    // Defect read with lists present; default format 4, formats 0 and 4 supported
    task automatic run_def(input logic p, input logic g, input logic [2:0] f, input logic [15:0] alloc);
        logic [2:0] rf;
        logic [15:0] pl, len, n;
        logic [7:0] hdr[4];
        rf = (f == 3'h0 || f == 3'h4) ? f : 3'h4;
        pl = p ? 16'(cnt_p) << ((rf == cdq_pkg::FMT_BLOCK) ? 2 : 3) : 16'h0;
        len = pl + (g ? 16'(cnt_g) << ((rf == cdq_pkg::FMT_BLOCK) ? 2 : 3) : 16'h0);
        hdr = '{8'h00, {3'h0, p, g, rf}, len[15:8], len[7:0]};
        n = (alloc < len + 16'h4) ? alloc : len + 16'h4;
        for (int k = 0; k < n; k++)
            exp_q.push_back(k < 4 ? hdr[k] : (k - 4 < pl) ? dl_exp(1'b0, 16'(k - 4)) : dl_exp(1'b1, 16'(k - 4 - pl)));
        st_q.push_back(rf != f ? {1'b1, cdq_pkg::SK_RECOV, cdq_pkg::ASC_DL_NF} : 13'h0);
        cmd(cdq_pkg::OP_DEF, 8'h00, {3'h0, p, g, f, 24'h0}, alloc, 8'h00);
    endtask : run_def

    task automatic stop_test;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    // Watchdog, well beyond the roughly 1500 cycles the sequence needs
    initial begin
        #1500000;
        num_errors++;
        $display("ERROR watchdog expected done seen hang");
        stop_test();
    end

    // Main sequence
    initial begin
        logic [31:0] q;
        logic [31:0] lba;
        logic [20:0] dtab[7];
        dtab = '{{1'b1, 1'b0, 3'h0, 16'hffff}, {1'b0, 1'b1, 3'h4, 16'hffff}, {1'b1, 1'b1, 3'h4, 16'hffff},
                 {1'b0, 1'b0, 3'h0, 16'hffff}, {1'b1, 1'b1, 3'h0, 16'h0004}, {1'b1, 1'b1, 3'h4, 16'h0009},
                 {1'b1, 1'b0, 3'h3, 16'hffff}};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // Reset values, an unmapped address, and an ignored unmapped write
        for (int i = 0; i < 9; i++) rd_chk(8'(i * 4), 32'h0);
        wr(8'h40, 32'hffff_ffff);
        rd_chk(8'h40, 32'h0);
        // Random last and delay addresses, fixed block length, random list counts
        last_lba = $random(seed);
        blen = 32'h0000_0200;
        dly = ($random(seed) & 32'h00ff_ffff) | 32'h0000_0100;
        q = $random(seed);
        cnt_p = 12'h3 + {10'h0, q[1:0]};
        cnt_g = 12'h2 + {10'h0, q[3:2]};
        wr(cdq_pkg::A_LAST, last_lba);
        wr(cdq_pkg::A_BLEN, blen);
        wr(cdq_pkg::A_DLY, dly);
        wr(cdq_pkg::A_DCFG, {13'h0, 3'h4, 8'h11, 8'h03});
        rd_chk(cdq_pkg::A_DCFG, {13'h0, 3'h4, 8'h11, 8'h03});
        wr(cdq_pkg::A_DCNT, {4'h0, cnt_g, 4'h0, cnt_p});
        // Full-medium capacity, then done flag latched while irq stays masked
        push_cap(last_lba, blen);
        st_q.push_back(13'h0);
        cmd(cdq_pkg::OP_CAP, 8'h00, 32'h0, 16'h0, 8'h00);
        rd_chk(cdq_pkg::A_ISTS, 32'h1);
        `CHK("irq_masked", 1'b0, irq)
        // Illegal requests: address with flag clear, relative flag, unknown opcode
        st_q.push_back({1'b1, cdq_pkg::SK_ILLEGAL, cdq_pkg::ASC_INV_FIELD});
        cmd(cdq_pkg::OP_CAP, 8'h00, 32'h1, 16'h0, 8'h00);
        st_q.push_back({1'b1, cdq_pkg::SK_ILLEGAL, cdq_pkg::ASC_INV_FIELD});
        cmd(cdq_pkg::OP_CAP, 8'h01, 32'h0, 16'h0, 8'h00);
        st_q.push_back({1'b1, cdq_pkg::SK_ILLEGAL, cdq_pkg::ASC_INV_OP});
        cmd(8'h12, 8'h00, 32'h0, 16'h0, 8'h00);
        // Partial medium: asked address below, then above, the delay point
        for (int i = 0; i < 2; i++) begin
            lba = i ? dly + 32'h5 : dly - 32'h3;
            push_cap(i ? lba : dly, blen);
            st_q.push_back(13'h0);
            cmd(cdq_pkg::OP_CAP, 8'h00, lba, 16'h0, 8'h01);
        end
        // Every list selection, truncation, header-only and unsupported format
        for (int i = 0; i < 7; i++) run_def(dtab[i][20], dtab[i][19], dtab[i][18:16], dtab[i][15:0]);
        // Unmask raises irq, clearing the status drops it
        wr(cdq_pkg::A_IMSK, 32'h3);
        repeat (3) @(posedge clk);
        `CHK("irq_set", 1'b1, irq)
        wr(cdq_pkg::A_ISTS, 32'h3);
        repeat (3) @(posedge clk);
        `CHK("irq_clear", 1'b0, irq)
        // Lists absent, then a medium fault, which wins
        wr(cdq_pkg::A_DCFG, {13'h0, 3'h4, 8'h11, 8'h00});
        st_q.push_back({1'b1, cdq_pkg::SK_NONE, cdq_pkg::ASC_DL_NF});
        cmd(cdq_pkg::OP_DEF, 8'h00, 32'h1800_0000, 16'hffff, 8'h00);
        rd_chk(cdq_pkg::A_SENSE, {16'h0, cdq_pkg::ASC_DL_NF, 4'h0, cdq_pkg::SK_NONE});
        `CHK("irq_check", 1'b1, irq)
        wr(cdq_pkg::A_DCFG, {13'h0, 3'h4, 8'h11, 8'h04});
        st_q.push_back({1'b1, cdq_pkg::SK_MEDIUM, cdq_pkg::ASC_DL_NF});
        cmd(cdq_pkg::OP_DEF, 8'h00, 32'h1800_0000, 16'hffff, 8'h00);
        stop_test();
    end
endmodule : tb_top
